// File: dv/psel_seq_model.sv
// Purpose: stand-in for the start-up sequencer on the far side of the block
// Assumes: same clock as the block; answers only while a sequence runs
// Notes: mode 0 finishes, 1 reports a failure, 2 never answers (timeout path)
`timescale 1ns/100ps
module psel_seq_model #(
   parameter int DLY = 5
) (
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic [1:0] mode_i,
   output logic done_o,
   output logic fail_o
);
   int cnt_q;
   always_ff @(posedge clk_i)
   begin
      cnt_q <= run_i ? cnt_q + 1 : 0;
   end
   // outputs drop once the run ends, so a stale answer is never seen
   assign done_o = run_i && cnt_q >= DLY && mode_i == 2'h0;
   assign fail_o = run_i && cnt_q >= DLY && mode_i == 2'h1;
endmodule : psel_seq_model

// File: dv/psel_top_bench.sv
// Purpose: register-level tests of power-state events and cause logs
// Assumes: sequence limit shortened to 50 cycles
// Notes: byte enables tied on; every event is a pulse long enough to pass the sync
`timescale 1ns/100ps
module psel_top_bench;
   localparam int LIM = 50;
   localparam logic [16:0] A_PS = {psel_pkg::IDX_PWR_STATE, 2'h0};
   localparam logic [16:0] A_ON = {psel_pkg::IDX_ON_CAUSE, 2'h0};
   localparam logic [16:0] A_OFF = {psel_pkg::IDX_OFF_CAUSE, 2'h0};
   localparam logic [16:0] A_CFG = {psel_pkg::IDX_SRC_CFG, 2'h0};
   localparam int ALM = 0, GPI = 1, BTN = 2, WDG = 3, SLO = 4, SHD = 5, HWR = 8, CNV = 9;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic sok = 1'b0;
   logic [9:0] ev = 10'h000;
   logic [16:0] adr = 17'h00000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h00000000;
   logic [1:0] mode = 2'h0;
   logic [31:0] rdata;
   logic waitr, son, slp, run, done, fail;
   logic [15:0] fexp [3] = '{16'h0400, 16'h0200, 16'h2000};
   int err_count = 0;
   int n_tests = 0;
   always #4 clk = ~clk;
   psel_top #(.ON_SEQ_LIMIT_CYC(LIM)) i_dut (.CLK_I(clk), .SRST_I(rst), .CE_I(ce),
      .AV_ADDRESS_I(adr), .AV_READ_I(rd), .AV_WRITE_I(wr), .AV_BYTEENABLE_I(4'hF),
      .AV_WRITEDATA_I(wd), .AV_READDATA_O(rdata), .AV_WAITREQUEST_O(waitr),
      .ALARM_I(ev[0]), .GPIO_REQ_I(ev[1]), .BUTTON_REQ_I(ev[2]), .WDOG_TIMEOUT_I(ev[3]),
      .SUPPLY_LOW_I(ev[4]), .SUPPLY_SHUTDOWN_I(ev[5]), .SUPPLY_OK_I(sok), .OVERTEMP_I(ev[6]),
      .REG_ERROR_I(ev[7]), .HW_RESET_I(ev[8]), .CNV_UNDERVOLT_I(ev[9]), .SEQ_DONE_I(done),
      .SEQ_FAIL_I(fail), .SYSTEM_ON_O(son), .SLEEP_O(slp), .SEQ_RUN_O(run));
   psel_seq_model i_seq (.clk_i(clk), .run_i(run), .mode_i(mode), .done_o(done),
      .fail_o(fail));
   task end_of_test;
      if (err_count == 0 && n_tests > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
         err_count++;
      end
   endtask : cmp
   // request held until waitrequest is sampled low; a hung slave ends the run
   task bus(input logic w, input logic [16:0] a, input logic [15:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      adr <= a;
      wd <= {16'h0000, d};
      wr <= w;
      rd <= !w;
      n = 0;
      @(posedge clk);
      while (waitr !== 1'b0)
      begin
         n++;
         @(posedge clk);
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      // the slave answers one cycle after the taking edge
      cmp("bus answer", 32'h1, n);
   endtask : bus
   task wr_reg(input logic [16:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr_reg
   task chk(input logic [16:0] a, input logic [15:0] e);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, q);
      cmp($sformatf("register %h", a), {16'h0000, e}, q);
   endtask : chk
   task settle;
      int n;
      repeat (6) @(posedge clk);
      n = 0;
      while (run !== 1'b0 && n < 300)
      begin
         n++;
         @(posedge clk);
      end
      cmp("sequence end", 32'h1, {31'h0, n < 300});
      repeat (2) @(posedge clk);
   endtask : settle
   task pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      repeat (5) @(posedge clk);
      ev[i] <= 1'b0;
      settle;
   endtask : pulse
   function automatic logic [15:0] b(input int p);
      return 16'h0001 << p;
   endfunction : b
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      chk(A_ON, 16'h0000);
      chk(A_OFF, 16'h0000);
      chk(17'h00100, 16'h0000);
      pulse(ALM);
      cmp("system on", 32'h0, son);
      sok <= 1'b1;
      wr_reg(A_PS, 16'h8000);
      cmp("system on", 32'h0, son);
      pulse(ALM);
      cmp("system on", 32'h1, son);
      chk(A_ON, b(15) | b(5));
      wr_reg(A_ON, 16'hFFFF);
      chk(A_ON, b(15) | b(5));
      wr_reg(A_PS, 16'hC000);
      cmp("sleep", 32'h1, slp);
      chk(A_OFF, 16'h0000);
      pulse(ALM);
      chk(A_ON, b(5));
      cmp("sleep", 32'h0, slp);
      wr_reg(A_PS, 16'hC000);
      wr_reg(A_PS, 16'h8000);
      chk(A_ON, b(6));
      wr_reg(A_PS, 16'h0000);
      chk(A_OFF, b(6));
      chk(A_ON, b(6));
      wr_reg(A_CFG, 16'h0002);
      pulse(GPI);
      chk(A_ON, b(15) | b(11));
      pulse(GPI);
      chk(A_OFF, b(11));
      wr_reg(A_CFG, 16'h0004);
      pulse(BTN);
      chk(A_ON, b(15) | b(4));
      wr_reg(A_PS, 16'hC000);
      pulse(BTN);
      chk(A_ON, b(4));
      wr_reg(A_CFG, 16'h0003);
      pulse(GPI);
      cmp("sleep", 32'h1, slp);
      pulse(GPI);
      chk(A_ON, b(11));
      wr_reg(A_CFG, 16'h0008);
      pulse(BTN);
      chk(A_OFF, b(4));
      wr_reg(A_CFG, 16'h0000);
      pulse(ALM);
      wr_reg(A_PS, 16'hC000);
      pulse(WDG);
      chk(A_ON, b(7));
      wr_reg(A_PS, 16'hC000);
      pulse(SLO);
      chk(A_ON, b(10));
      wr_reg(A_CFG, 16'h0020);
      pulse(SLO);
      chk(A_OFF, b(10));
      pulse(HWR);
      chk(A_ON, b(1));
      pulse(CNV);
      chk(A_ON, b(3));
      wr_reg(A_CFG, 16'h0010);
      pulse(WDG);
      chk(A_ON, b(0));
      wr_reg(A_CFG, 16'h0100);
      settle;
      chk(A_ON, b(2));
      chk(A_OFF, b(10));
      for (int i = 0; i < 3; i++)
      begin
         pulse(SHD + i);
         cmp("system on", 32'h0, {31'h0, son});
         chk(A_OFF, fexp[i]);
         pulse(ALM);
      end
      wr_reg(A_PS, 16'h0000);
      mode <= 2'h1;
      pulse(ALM);
      chk(A_OFF, b(12));
      mode <= 2'h0;
      pulse(ALM);
      wr_reg(A_PS, 16'h0000);
      mode <= 2'h2;
      pulse(ALM);
      chk(A_OFF, b(12));
      // a frozen block must miss a pin pulse altogether
      mode <= 2'h0;
      ce <= 1'b0;
      pulse(ALM);
      ce <= 1'b1;
      cmp("system on", 32'h0, {31'h0, son});
      chk(A_ON, b(15) | b(5));
      // power-on-only pin starts ON but never turns the system off
      wr_reg(A_CFG, 16'h0001);
      pulse(GPI);
      chk(A_ON, b(15) | b(11));
      pulse(GPI);
      cmp("system on", 32'h1, {31'h0, son});
      chk(A_OFF, b(12));
      end_of_test;
   end
   // the whole sequence needs well under a thousand cycles; this 20000-cycle limit is ample slack
   initial
   begin
      #160000;
      err_count++;
      end_of_test;
   end
endmodule : psel_top_bench

// File: dv/psel_top_monitor.sv
// Purpose: port-level assertions for the power-state event logger
// Assumes: one clock, synchronous active-high reset
// Notes: pins pass two sync flops and an edge stage, hence five-cycle windows
`timescale 1ns/100ps
module psel_top_monitor #(
   parameter int ON_SEQ_LIMIT_CYC = 50
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   input wire logic [16:0] AV_ADDRESS_I,
   input wire logic AV_READ_I,
   input wire logic AV_WRITE_I,
   input wire logic [3:0] AV_BYTEENABLE_I,
   input wire logic [31:0] AV_WRITEDATA_I,
   input wire logic [31:0] AV_READDATA_O,
   input wire logic AV_WAITREQUEST_O,
   input wire logic SUPPLY_SHUTDOWN_I,
   input wire logic SUPPLY_OK_I,
   input wire logic OVERTEMP_I,
   input wire logic REG_ERROR_I,
   input wire logic SYSTEM_ON_O,
   input wire logic SLEEP_O,
   input wire logic SEQ_RUN_O
);
   int run_cnt_q;
   always_ff @(posedge CLK_I)
   begin
      if (SRST_I || !SEQ_RUN_O)
      begin
         run_cnt_q <= 0;
      end
      else if (CE_I)
      begin
         run_cnt_q <= run_cnt_q + 1;
      end
   end
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (SRST_I);
   chk_bus_answer: assert property ((AV_READ_I || AV_WRITE_I) && AV_WAITREQUEST_O && CE_I
      |=> !AV_WAITREQUEST_O) else $error("bus request not answered next cycle");
   chk_answer_once: assert property (!AV_WAITREQUEST_O |=> AV_WAITREQUEST_O)
      else $error("waitrequest low for more than one cycle");
   chk_idle_wait: assert property (!AV_READ_I && !AV_WRITE_I |=> AV_WAITREQUEST_O)
      else $error("answer without a request");
   chk_upper_zero: assert property (
      !AV_WAITREQUEST_O |-> AV_READDATA_O[31:16] == 16'h0000) else $error("upper bits set");
   chk_sleep_on: assert property (SLEEP_O |-> SYSTEM_ON_O && !SEQ_RUN_O)
      else $error("sleep flag outside an on state");
   chk_refuse_start: assert property ((!SUPPLY_OK_I)[*4] |-> !$rose(SEQ_RUN_O))
      else $error("on sequence started with supply not ok");
   chk_shutdown_off: assert property (SUPPLY_SHUTDOWN_I[*5] |-> !SYSTEM_ON_O)
      else $error("system on during supply shutdown");
   chk_overtemp_off: assert property (OVERTEMP_I[*5] |-> !SYSTEM_ON_O)
      else $error("system on during over-temperature");
   chk_regerr_off: assert property (REG_ERROR_I[*5] |-> !SYSTEM_ON_O)
      else $error("system on during regulator error");
   chk_seq_limit: assert property (run_cnt_q <= ON_SEQ_LIMIT_CYC + 1)
      else $error("on sequence ran past its limit");
   chk_sw_off: assert property (
      AV_WRITE_I && AV_WAITREQUEST_O && CE_I && AV_BYTEENABLE_I[1] && !AV_WRITEDATA_I[15]
      && AV_ADDRESS_I == {psel_pkg::IDX_PWR_STATE, 2'h0} |-> ##[1:2] !SYSTEM_ON_O)
      else $error("software off not obeyed");
endmodule : psel_top_monitor
bind psel_top psel_top_monitor #(.ON_SEQ_LIMIT_CYC(ON_SEQ_LIMIT_CYC)) i_mon (
   .CLK_I(CLK_I), .SRST_I(SRST_I), .CE_I(CE_I), .AV_ADDRESS_I(AV_ADDRESS_I),
   .AV_READ_I(AV_READ_I), .AV_WRITE_I(AV_WRITE_I), .AV_BYTEENABLE_I(AV_BYTEENABLE_I),
   .AV_WRITEDATA_I(AV_WRITEDATA_I), .AV_READDATA_O(AV_READDATA_O),
   .AV_WAITREQUEST_O(AV_WAITREQUEST_O), .SUPPLY_SHUTDOWN_I(SUPPLY_SHUTDOWN_I),
   .SUPPLY_OK_I(SUPPLY_OK_I), .OVERTEMP_I(OVERTEMP_I), .REG_ERROR_I(REG_ERROR_I),
   .SYSTEM_ON_O(SYSTEM_ON_O), .SLEEP_O(SLEEP_O), .SEQ_RUN_O(SEQ_RUN_O));

// File: hdl/psel_pkg.sv
// Purpose: constants for the power-state event source logger
// Assumes: 125 MHz clock, Avalon-MM byte addresses, register at byte address 4 x index
// Notes on behaviour
// - off-cause bit 13: latest OFF came from the always-on regulator error
// - off-cause bit 12: latest OFF came from a power sequence failure
// - off-cause bit 11: latest OFF requested by a general-purpose pin
// - off-cause bit 10: latest OFF came from supply low or shutdown threshold
// - off-cause bit 9: latest OFF forced by over-temperature
// - off-cause bit 6: latest OFF commanded by software clearing system-on
// - off-cause bit 4: latest OFF requested by the push-button
// - on-cause bit 1: latest ON was the restart after hardware reset
// - on-cause bit 0: latest ON was a watchdog device reset
// - alarm in OFF starts ON, logs ON indicator and alarm cause
// - alarm in SLEEP starts WAKE, logs alarm cause only
// - pin power-on request starts ON; sleep/wake pin starts WAKE
// - button ON or WAKE request starts transition, logs button cause
// - software writing sleep bit 0 wakes and logs software wake
// - watchdog timeout wakes in wake mode, resets in reset mode
// - supply low wakes in wake mode, turns off in off mode
// - resets do OFF then ON, logged as reset event in on-cause; code goes straight to the ON sequence, no OFF
// - software writing system-on 0 turns off, logs software off
// - supply below shutdown threshold always forces OFF, logged as supply
// - startup failure of supplies or clocks forces OFF as sequence failure
// - sleep by software or pin; sleep never logged in off-cause
// - ON sequence refused unless supply is above system-ok threshold
// - on-cause updates only on ON/WAKE, off-cause only on OFF
// - ON sequence unfinished after 2 seconds is a sequence failure
// - system-on reads 1 in ON or SLEEP; writing 1 does nothing
package psel_pkg;
   localparam int CLK_HZ = 125_000_000;
   localparam int ON_SEQ_LIMIT_MS = 2000;
   localparam int ON_SEQ_LIMIT_CYC = (CLK_HZ / 1000) * ON_SEQ_LIMIT_MS;
   // register indices; byte address is four times the index
   localparam logic [14:0] IDX_PWR_STATE = 15'h4003;
   localparam logic [14:0] IDX_ON_CAUSE = 15'h400E;
   localparam logic [14:0] IDX_OFF_CAUSE = 15'h400F;
   localparam logic [14:0] IDX_SRC_CFG = 15'h4020;
   // power state control bits
   localparam int POS_SYSTEM_ON = 15;
   localparam int POS_SLEEP_STATE = 14;
   // source config bits
   localparam int POS_GPIO_MODE = 0;
   localparam int POS_BTN_ACT = 2;
   localparam int POS_WDOG_RESET = 4;
   localparam int POS_SUPPLY_OFF = 5;
   localparam int POS_SW_RESET = 8;
   localparam logic [5:0] SRC_CFG_RST = 6'h00;
   localparam logic [15:0] CAUSE_LOG_RST = 16'h0000;
   // on-cause bits
   localparam int ON_VERSUS_WAKE_INDICATOR = 15;
   localparam int ON_BY_GPIO = 11;
   localparam int WAKE_BY_SUPPLY_LOW = 10;
   localparam int WAKE_BY_WATCHDOG = 7;
   localparam int WAKE_BY_SOFTWARE = 6;
   localparam int START_BY_ALARM = 5;
   localparam int ON_BY_BUTTON = 4;
   localparam int CAUSE_REGULATOR_UNDERVOLT_RESTART = 3;
   localparam int CAUSE_SOFTWARE_RESTART = 2;
   localparam int CAUSE_HARDWARE_RESTART = 1;
   localparam int CAUSE_WATCHDOG_RESTART = 0;
   // off-cause bits
   localparam int OFF_BY_INTERNAL_REGULATOR_ERROR = 13;
   localparam int OFF_BY_SEQUENCE_FAILURE = 12;
   localparam int OFF_BY_GPIO = 11;
   localparam int OFF_BY_SUPPLY_LOW = 10;
   localparam int OFF_BY_OVERTEMPERATURE = 9;
   localparam int OFF_BY_SOFTWARE = 6;
   localparam int OFF_BY_BUTTON = 4;
   // pin request modes
   localparam logic [1:0] GPIO_NONE = 2'h0;
   localparam logic [1:0] GPIO_POWER_ON = 2'h1;
   localparam logic [1:0] GPIO_POWER_ONOFF = 2'h2;
   localparam logic [1:0] GPIO_SLEEP_WAKE = 2'h3;
   localparam logic [1:0] BTN_IGNORE = 2'h0;
   localparam logic [1:0] BTN_ON_REQ = 2'h1;
   localparam logic [1:0] BTN_OFF_REQ = 2'h2;
   // synchronised pin vector positions
   localparam int PIN_ALARM = 0;
   localparam int PIN_GPIO = 1;
   localparam int PIN_BUTTON = 2;
   localparam int PIN_WDOG = 3;
   localparam int PIN_SUPPLY_LOW = 4;
   localparam int PIN_SHUTDOWN = 5;
   localparam int PIN_SYSOK = 6;
   localparam int PIN_OVERTEMP = 7;
   localparam int PIN_REG_ERR = 8;
   localparam int PIN_HW_RESET = 9;
   localparam int PIN_CNV_UV = 10;
   localparam int PIN_COUNT = 11;
   typedef enum {ST_OFF, ST_STARTING, ST_ON, ST_SLEEP} psel_state_t;
endpackage : psel_pkg

// File: hdl/psel_sync.sv
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: pins are asynchronous levels
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module psel_sync #(
   parameter int W = 1
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   input wire logic [W-1:0] PINS_I,
   output logic [W-1:0] SYNC_O
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } psel_sync_t;
   if (W < 1)
   begin : g_width_check
      $error("W must be at least 1");
   end
   psel_sync_t q;
   psel_sync_t d;
   always_comb
   begin
      d.meta = PINS_I;
      d.sync = q.meta;
   end
   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         q <= '0;
      end
      else if (CE_I)
      begin
         q <= d;
      end
   end
   assign SYNC_O = q.sync;
endmodule : psel_sync

// File: hdl/psel_top.sv
// Purpose: power-state transitions from event sources, with on/off cause logs
// Assumes: Avalon-MM slave with waitrequest; sequencer on the same clock
// Notes: wake is immediate; only ON runs the sequencer and its time limit
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
module psel_top #(
   parameter int ON_SEQ_LIMIT_CYC = psel_pkg::ON_SEQ_LIMIT_CYC
) (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic CE_I,
   input wire logic [16:0] AV_ADDRESS_I,
   input wire logic AV_READ_I,
   input wire logic AV_WRITE_I,
   input wire logic [3:0] AV_BYTEENABLE_I,
   input wire logic [31:0] AV_WRITEDATA_I,
   output logic [31:0] AV_READDATA_O,
   output logic AV_WAITREQUEST_O,
   input wire logic ALARM_I,
   input wire logic GPIO_REQ_I,
   input wire logic BUTTON_REQ_I,
   input wire logic WDOG_TIMEOUT_I,
   input wire logic SUPPLY_LOW_I,
   input wire logic SUPPLY_SHUTDOWN_I,
   input wire logic SUPPLY_OK_I,
   input wire logic OVERTEMP_I,
   input wire logic REG_ERROR_I,
   input wire logic HW_RESET_I,
   input wire logic CNV_UNDERVOLT_I,
   input wire logic SEQ_DONE_I,
   input wire logic SEQ_FAIL_I,
   output logic SYSTEM_ON_O,
   output logic SLEEP_O,
   output logic SEQ_RUN_O
);
   localparam int PN = psel_pkg::PIN_COUNT;

   // the timer is 28 bits wide, so a larger limit would wrap
   if (ON_SEQ_LIMIT_CYC < 1 || ON_SEQ_LIMIT_CYC > 32'h0FFFFFFF)
   begin : g_limit_check
      $error("ON_SEQ_LIMIT_CYC out of range");
   end

   typedef struct packed {
      psel_pkg::psel_state_t st;
      logic [27:0] timer;
      logic [PN-1:0] prev;
      logic [15:0] on_log;
      logic [15:0] off_log;
      logic [5:0] cfg;
      logic wait_n;
      logic [31:0] rdata;
      logic sys_on;
      logic sleep;
      logic seq_run;
   } psel_regs_t;

   psel_regs_t q;
   psel_regs_t d;
   logic [PN-1:0] pins;
   logic [PN-1:0] sync;

   assign pins = {CNV_UNDERVOLT_I, HW_RESET_I, REG_ERROR_I, OVERTEMP_I, SUPPLY_OK_I,
                  SUPPLY_SHUTDOWN_I, SUPPLY_LOW_I, WDOG_TIMEOUT_I, BUTTON_REQ_I,
                  GPIO_REQ_I, ALARM_I};

   psel_sync #(
      .W(PN)
   ) u_sync (
      .CLK_I(CLK_I),
      .SRST_I(SRST_I),
      .CE_I(CE_I),
      .PINS_I(pins),
      .SYNC_O(sync)
   );

   function automatic logic [15:0] one_bit(input int pos);
      one_bit = 16'h0001 << pos;
   endfunction : one_bit

   function automatic logic is_alive(input psel_pkg::psel_state_t s);
      is_alive = (s != psel_pkg::ST_OFF);
   endfunction : is_alive

   localparam logic [27:0] LIMIT_LOAD = 28'(ON_SEQ_LIMIT_CYC - 1);
   localparam logic [15:0] ON_MASK = 16'h8CFF;
   localparam logic [15:0] OFF_MASK = 16'h3E50;

   psel_regs_t rst_val;
   always_comb
   begin
      rst_val = '0;
      rst_val.st = psel_pkg::ST_OFF;
      rst_val.on_log = psel_pkg::CAUSE_LOG_RST;
      rst_val.off_log = psel_pkg::CAUSE_LOG_RST;
      rst_val.cfg = psel_pkg::SRC_CFG_RST;
      rst_val.wait_n = 1'b1;
   end

   always_comb
   begin
      logic [PN-1:0] rise;
      logic [14:0] idx;
      logic take;
      logic wr_ctrl;
      logic sw_off;
      logic sw_sleep;
      logic sw_wake;
      logic sw_rst;
      logic [1:0] gmode;
      logic [1:0] bact;
      logic alive;
      logic go_off;
      logic [15:0] off_v;
      logic go_on;
      logic [15:0] on_v;
      logic [15:0] wake_v;
      logic [15:0] rst_v;
      logic go_sleep;
      rise = '0;
      idx = '0;
      take = 1'b0;
      wr_ctrl = 1'b0;
      sw_off = 1'b0;
      sw_sleep = 1'b0;
      sw_wake = 1'b0;
      sw_rst = 1'b0;
      gmode = '0;
      bact = '0;
      alive = 1'b0;
      go_off = 1'b0;
      off_v = '0;
      go_on = 1'b0;
      on_v = '0;
      wake_v = '0;
      rst_v = '0;
      go_sleep = 1'b0;
      d = q;
      d.prev = sync;
      d.wait_n = 1'b1;
      rise = sync & ~q.prev;
      gmode = q.cfg[psel_pkg::POS_GPIO_MODE +: 2];
      bact = q.cfg[psel_pkg::POS_BTN_ACT +: 2];
      alive = is_alive(q.st);

      // bus: a request is taken while waitrequest stands high, answered next cycle
      idx = AV_ADDRESS_I[16:2];
      take = (AV_READ_I | AV_WRITE_I) & q.wait_n;
      wr_ctrl = take & AV_WRITE_I & AV_BYTEENABLE_I[1] & (idx == psel_pkg::IDX_PWR_STATE);
      sw_off = wr_ctrl & ~AV_WRITEDATA_I[psel_pkg::POS_SYSTEM_ON];
      // writing system-on as 1 is simply ignored
      sw_sleep = wr_ctrl & AV_WRITEDATA_I[psel_pkg::POS_SLEEP_STATE];
      sw_wake = wr_ctrl & ~AV_WRITEDATA_I[psel_pkg::POS_SLEEP_STATE];
      sw_rst = take & AV_WRITE_I & AV_BYTEENABLE_I[1] & (idx == psel_pkg::IDX_SRC_CFG)
               & AV_WRITEDATA_I[psel_pkg::POS_SW_RESET];
      if (take)
      begin
         d.wait_n = 1'b0;
         d.rdata = '0;
         if (AV_WRITE_I && AV_BYTEENABLE_I[0] && idx == psel_pkg::IDX_SRC_CFG)
         begin
            d.cfg = AV_WRITEDATA_I[5:0];
         end
         if (AV_READ_I)
         begin
            case (idx)
               psel_pkg::IDX_PWR_STATE:
               begin
                  d.rdata[psel_pkg::POS_SYSTEM_ON] = q.sys_on;
                  d.rdata[psel_pkg::POS_SLEEP_STATE] = q.sleep;
               end
               psel_pkg::IDX_ON_CAUSE: d.rdata[15:0] = q.on_log & ON_MASK;
               psel_pkg::IDX_OFF_CAUSE: d.rdata[15:0] = q.off_log & OFF_MASK;
               psel_pkg::IDX_SRC_CFG: d.rdata[5:0] = q.cfg;
               default: d.rdata = '0;
            endcase
         end
      end

      // restart sources, each a direct ON with no OFF first
      rst_v[psel_pkg::CAUSE_HARDWARE_RESTART] = rise[psel_pkg::PIN_HW_RESET];
      rst_v[psel_pkg::CAUSE_WATCHDOG_RESTART] =
         rise[psel_pkg::PIN_WDOG] & q.cfg[psel_pkg::POS_WDOG_RESET];
      rst_v[psel_pkg::CAUSE_SOFTWARE_RESTART] = sw_rst;
      rst_v[psel_pkg::CAUSE_REGULATOR_UNDERVOLT_RESTART] = rise[psel_pkg::PIN_CNV_UV];

      // wake sources, looked at only in SLEEP
      wake_v[psel_pkg::WAKE_BY_SOFTWARE] = sw_wake;
      wake_v[psel_pkg::WAKE_BY_WATCHDOG] =
         rise[psel_pkg::PIN_WDOG] & ~q.cfg[psel_pkg::POS_WDOG_RESET];
      wake_v[psel_pkg::START_BY_ALARM] = rise[psel_pkg::PIN_ALARM];
      wake_v[psel_pkg::ON_BY_GPIO] = rise[psel_pkg::PIN_GPIO] & (gmode == psel_pkg::GPIO_SLEEP_WAKE);
      wake_v[psel_pkg::WAKE_BY_SUPPLY_LOW] =
         rise[psel_pkg::PIN_SUPPLY_LOW] & ~q.cfg[psel_pkg::POS_SUPPLY_OFF];
      wake_v[psel_pkg::ON_BY_BUTTON] =
         rise[psel_pkg::PIN_BUTTON] & (bact == psel_pkg::BTN_ON_REQ);

      // forced offs outrank every request; order settles ties
      if (alive && sync[psel_pkg::PIN_SHUTDOWN])
      begin
         go_off = 1'b1;
         off_v = one_bit(psel_pkg::OFF_BY_SUPPLY_LOW);
      end
      else if (alive && sync[psel_pkg::PIN_OVERTEMP])
      begin
         go_off = 1'b1;
         off_v = one_bit(psel_pkg::OFF_BY_OVERTEMPERATURE);
      end
      else if (alive && sync[psel_pkg::PIN_REG_ERR])
      begin
         go_off = 1'b1;
         off_v = one_bit(psel_pkg::OFF_BY_INTERNAL_REGULATOR_ERROR);
      end
      else if (q.st == psel_pkg::ST_STARTING && (SEQ_FAIL_I || q.timer == '0))
      begin
         go_off = 1'b1;
         off_v = one_bit(psel_pkg::OFF_BY_SEQUENCE_FAILURE);
      end
      else if (rst_v != '0)
      begin
         go_on = 1'b1;
         on_v = rst_v;
      end
      else if (alive && sw_off)
      begin
         go_off = 1'b1;
         off_v = one_bit(psel_pkg::OFF_BY_SOFTWARE);
      end
      else if (alive && rise[psel_pkg::PIN_BUTTON] && bact == psel_pkg::BTN_OFF_REQ)
      begin
         go_off = 1'b1;
         off_v = one_bit(psel_pkg::OFF_BY_BUTTON);
      end
      else if (q.st == psel_pkg::ST_ON && rise[psel_pkg::PIN_GPIO]
               && gmode == psel_pkg::GPIO_POWER_ONOFF)
      begin
         go_off = 1'b1;
         off_v = one_bit(psel_pkg::OFF_BY_GPIO);
      end
      else if (alive && rise[psel_pkg::PIN_SUPPLY_LOW] && q.cfg[psel_pkg::POS_SUPPLY_OFF])
      begin
         go_off = 1'b1;
         off_v = one_bit(psel_pkg::OFF_BY_SUPPLY_LOW);
      end
      else if (q.st == psel_pkg::ST_OFF)
      begin
         on_v[psel_pkg::START_BY_ALARM] = rise[psel_pkg::PIN_ALARM];
         on_v[psel_pkg::ON_BY_GPIO] = rise[psel_pkg::PIN_GPIO]
            & (gmode == psel_pkg::GPIO_POWER_ON || gmode == psel_pkg::GPIO_POWER_ONOFF);
         on_v[psel_pkg::ON_BY_BUTTON] =
            rise[psel_pkg::PIN_BUTTON] & (bact == psel_pkg::BTN_ON_REQ);
         if (on_v != '0)
         begin
            go_on = 1'b1;
            on_v[psel_pkg::ON_VERSUS_WAKE_INDICATOR] = 1'b1;
         end
      end
      else if (q.st == psel_pkg::ST_SLEEP)
      begin
         if (wake_v != '0)
         begin
            // wake: indicator stays 0, whole log replaced
            d.on_log = wake_v;
            d.st = psel_pkg::ST_ON;
         end
      end
      else if (q.st == psel_pkg::ST_ON)
      begin
         go_sleep = sw_sleep | (rise[psel_pkg::PIN_GPIO] & (gmode == psel_pkg::GPIO_SLEEP_WAKE));
         if (go_sleep)
         begin
            d.st = psel_pkg::ST_SLEEP;
         end
      end
      else if (q.st == psel_pkg::ST_STARTING && SEQ_DONE_I)
      begin
         d.st = psel_pkg::ST_ON;
      end

      if (q.st == psel_pkg::ST_STARTING)
      begin
         d.timer = q.timer - 28'h0000001;
      end
      if (go_off)
      begin
         d.st = psel_pkg::ST_OFF;
         d.off_log = off_v;
      end
      else if (go_on)
      begin
         // an ON is refused, and nothing logged, while the supply is not ok
         if (sync[psel_pkg::PIN_SYSOK])
         begin
            d.st = psel_pkg::ST_STARTING;
            d.timer = LIMIT_LOAD;
            d.on_log = on_v;
         end
         else
         begin
            d.st = psel_pkg::ST_OFF;
         end
      end

      d.sys_on = is_alive(d.st);
      d.sleep = (d.st == psel_pkg::ST_SLEEP);
      d.seq_run = (d.st == psel_pkg::ST_STARTING);
   end

   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         q <= rst_val;
      end
      else if (CE_I)
      begin
         q <= d;
      end
   end

   assign AV_READDATA_O = q.rdata;
   assign AV_WAITREQUEST_O = q.wait_n;
   assign SYSTEM_ON_O = q.sys_on;
   assign SLEEP_O = q.sleep;
   assign SEQ_RUN_O = q.seq_run;
endmodule : psel_top
